// file: bench/test_twmr_top.sv
// Self-checking bench for the receive sequencer.
`timescale 1ns/10ps
`include "twmr_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_twmr_top;
  logic        clk_i, reset_n_i, awv, wv, br, arv, rr;
  logic        awr, wrdy, bv, arr, rv, scl_oe_n, sda_oe_n, slv_oe_n, irq, scl, sda;
  logic [7:0]  awa, ara, slv_addr;
  logic [31:0] wd, rdat, v;
  logic [1:0]  bresp_w, rresp_w, r, b_resp;
  int          n_mismatch = 0;
  int          check_count = 0;

  // Clock and open-drain lines with pull-ups.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  assign scl = scl_oe_n ? 1'b1 : 1'b0;
  assign sda = (sda_oe_n && slv_oe_n) ? 1'b1 : 1'b0;

  twmr_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp_w), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp_w), .s_axi_rvalid(rv), .s_axi_rready(rr), .scl_i(scl), .scl_o(),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n), .irq_o(irq));
  twmr_slave_model SLV (.scl_i(scl), .sda_i(sda), .sda_oe_n_o(slv_oe_n), .addr_o(slv_addr));

  // Ready is raised late on purpose so the slave must hold its answer for a cycle.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (awv || wv);
    while (!bv) @(posedge clk_i);
    br <= 1'b1;
    @(posedge clk_i);
    b_resp = bresp_w;
    br <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge clk_i);
    rr <= 1'b1;
    @(posedge clk_i);
    v = rdat;
    r = rresp_w;
    rr <= 1'b0;
  endtask

  // Masked read-compare; the status compare masks off the prescaler bits.
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus_rd(a);
    `CHK({r, v & {24'h0, m}}, {`TWMR_RESP_OKAY, 24'h0, e})
  endtask

  task automatic step(input logic [7:0] c, input logic [7:0] st);
    bus_wr(`TWMR_OFS_CONTROL, c);
    v = 32'h0;
    for (int t = 0; t < 300 && v[7] !== 1'b1; t++) bus_rd(`TWMR_OFS_CONTROL);
    `CHK(v[7], 1'b1)
    rchk(`TWMR_OFS_STATUS, 8'hF8, st);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence: registers, then read frames through 0x08, 0x40, 0x50, 0x58, 0x10 and 0x48.
  initial begin
    {awv, wv, br, arv, rr, awa, ara, wd} = '0;
    reset_n_i = 1'b0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rchk(`TWMR_OFS_CONTROL, 8'hFF, `TWMR_RST_CONTROL);
    rchk(`TWMR_OFS_STATUS, 8'hFF, `TWMR_RST_STATUS);
    rchk(`TWMR_OFS_DATA, 8'hFF, `TWMR_RST_DATA);
    bus_rd(8'h0C);
    `CHK({r, v}, {`TWMR_RESP_SLVERR, 32'h0})
    bus_wr(8'h0C, 8'h5A);
    `CHK(b_resp, `TWMR_RESP_SLVERR)
    bus_wr(`TWMR_OFS_STATUS, 8'h03);
    rchk(`TWMR_OFS_STATUS, 8'h07, 8'h03);
    bus_wr(`TWMR_OFS_DATA, 8'h12);
    rchk(`TWMR_OFS_CONTROL, 8'h08, 8'h08);
    rchk(`TWMR_OFS_DATA, 8'hFF, `TWMR_RST_DATA);
    step(8'hA5, `TWMR_ST_START);
    `CHK(irq, 1'b1)
    bus_wr(`TWMR_OFS_DATA, 8'h55);
    rchk(`TWMR_OFS_CONTROL, 8'h08, 8'h00);
    step(8'hC5, `TWMR_ST_AR_ACK);
    `CHK(slv_addr, 8'h55)
    step(8'hC5, `TWMR_ST_DR_ACK);
    rchk(`TWMR_OFS_DATA, 8'hFF, 8'hA5);
    step(8'h85, `TWMR_ST_DR_NACK);
    rchk(`TWMR_OFS_DATA, 8'hFF, 8'hA6);
    step(8'hA5, `TWMR_ST_RESTART);
    bus_wr(`TWMR_OFS_DATA, 8'h23);
    step(8'h85, `TWMR_ST_AR_NACK);
    step(8'hB5, `TWMR_ST_START);
    rchk(`TWMR_OFS_CONTROL, 8'h10, 8'h00);
    bus_wr(`TWMR_OFS_DATA, 8'h23);
    step(8'h85, `TWMR_ST_AR_NACK);
    bus_wr(`TWMR_OFS_CONTROL, 8'h95);
    v = 32'hFF;
    for (int t = 0; t < 50 && v[4] !== 1'b0; t++) bus_rd(`TWMR_OFS_CONTROL);
    `CHK({v[7], v[4], sda, irq}, 4'b0010)
    print_verdict();
  end

  // Watchdog: the sequence needs a few thousand cycles at most.
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule

// file: bench/twmr_slave_model.sv
// Behavioural slave transmitter on the two-wire bus.
`timescale 1ns/10ps
module twmr_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A,  // Own address.
  parameter logic [7:0] FIRST = 8'hA5   // First byte sent, then one more each byte.
) (
  input  wire logic       scl_i,       // Clock line.
  input  wire logic       sda_i,       // Data line.
  output logic            sda_oe_n_o,  // Pulls data low when zero.
  output logic [7:0]      addr_o       // Last address byte heard.
);
  event st;
  event sp;
  logic got_st;

  // Data edges while the clock line is high are START and STOP.
  always @(sda_i) begin
    if (scl_i === 1'b1 && sda_i === 1'b0) begin
      got_st = 1'b1;
      ->st;
    end
    if (scl_i === 1'b1 && sda_i === 1'b1) ->sp;
  end

  // Released means high through the pull-up, so no stale bit is ever left on the line.
  task automatic serve();
    logic [7:0] a;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      @(posedge scl_i);
      a = {a[6:0], sda_i};
    end
    addr_o = a;
    if (a[7:1] != ADDR || !a[0]) return;
    @(negedge scl_i);
    sda_oe_n_o = 1'b0;
    @(negedge scl_i);
    d = FIRST;
    forever begin
      for (int i = 7; i >= 0; i--) begin
        sda_oe_n_o = d[i];
        @(negedge scl_i);
      end
      sda_oe_n_o = 1'b1;
      @(posedge scl_i);
      if (sda_i) return;
      @(negedge scl_i);
      d = d + 8'h01;
    end
  endtask

  // A repeated START cuts the frame short and opens the next one at once.
  initial begin
    sda_oe_n_o = 1'b1;
    addr_o = 8'h00;
    @st;
    forever begin
      got_st = 1'b0;
      fork
        serve();
        @(st or sp);
      join_any
      disable fork;
      sda_oe_n_o = 1'b1;
      if (!got_st) @st;
    end
  end
endmodule

// file: bench/twmr_sva.sv
// Port checker for the receive sequencer, bound to its top module.
`timescale 1ns/10ps
`include "twmr_consts.svh"
module twmr_sva (
  input wire logic        clk_i,          // Clock.
  input wire logic        reset_n_i,      // Reset, low.
  input wire logic        s_axi_awvalid,  // Address valid.
  input wire logic        s_axi_awready,  // Address ready.
  input wire logic        s_axi_wvalid,   // Data valid.
  input wire logic        s_axi_wready,   // Data ready.
  input wire logic [1:0]  s_axi_bresp,    // Write response.
  input wire logic        s_axi_bvalid,   // Response valid.
  input wire logic        s_axi_bready,   // Response ready.
  input wire logic [7:0]  s_axi_araddr,   // Read address.
  input wire logic        s_axi_arvalid,  // Read valid.
  input wire logic        s_axi_arready,  // Read ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic [1:0]  s_axi_rresp,    // Read response.
  input wire logic        s_axi_rvalid,   // Data valid.
  input wire logic        s_axi_rready,   // Data ready.
  input wire logic        scl_oe_n_o,     // Clock pull.
  input wire logic        sda_oe_n_o,     // Data pull.
  input wire logic        scl_o,          // Clock drive.
  input wire logic        sda_o,          // Data drive.
  input wire logic        irq_o           // Interrupt.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Answers stand unchanged until taken; a slave that drops them loses the transfer.
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_drive_low: assert property (!scl_o && !sda_o) else $error("drive value not low");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h08
    |=> s_axi_rresp == `TWMR_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_bus_frozen: assert property (irq_o && $past(irq_o) |-> !scl_oe_n_o)
    else $error("clock line released while flag set");
  a_reset_idle: assert property ($rose(reset_n_i) |-> s_axi_awready && !s_axi_bvalid && sda_oe_n_o
    && scl_oe_n_o && !irq_o) else $error("outputs not idle after reset");
  a_scl_high_min: assert property ($rose(scl_oe_n_o) |=> scl_oe_n_o)
    else $error("clock high phase too short");
  c_flag_seen: cover property ($rose(irq_o));
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `TWMR_RESP_SLVERR);
  c_stop: cover property ($rose(sda_oe_n_o) && scl_oe_n_o);
endmodule

bind twmr_top twmr_sva SVA (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o),
  .scl_o(scl_o), .sda_o(sda_o));

// file: rtl/twmr_bus_monitor.sv
// Bus-busy tracker that watches START and STOP conditions on the serial bus.
`timescale 1ns/10ps
module twmr_bus_monitor (
  input  wire logic clk_i,      // System clock.
  input  wire logic reset_n_i,  // Synchronous reset, active low.
  input  wire logic scl_i,      // Synchronised clock line.
  input  wire logic sda_i,      // Synchronised data line.
  output logic      busy_o      // High between a START and the following STOP.
);

  logic sda_prev_q;
  wire  start_seen;
  wire  stop_seen;

  // Data edges while the clock line is high are bus conditions.
  assign start_seen = scl_i & sda_prev_q & ~sda_i;
  assign stop_seen  = scl_i & ~sda_prev_q & sda_i;

  // Busy is a level; any master's START, ours included, marks the bus taken.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sda_prev_q <= 1'b1;
      busy_o     <= 1'b0;
    end else begin
      sda_prev_q <= sda_i;
      if (start_seen) begin
        busy_o <= 1'b1;
      end else if (stop_seen) begin
        busy_o <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/twmr_consts.svh
// Register offsets, field positions, reset values, status codes and timing of the receive sequencer.
`ifndef TWMR_CONSTS_SVH
`define TWMR_CONSTS_SVH

// Byte addresses of the three registers on the register bus.
`define TWMR_OFS_CONTROL    8'h00
`define TWMR_OFS_STATUS     8'h04
`define TWMR_OFS_DATA       8'h08

// Field positions inside the control register.
`define TWMR_CTL_FLAG       7
`define TWMR_CTL_ACK_EN     6
`define TWMR_CTL_START      5
`define TWMR_CTL_STOP       4
`define TWMR_CTL_WCOL       3
`define TWMR_CTL_ENABLE     2
`define TWMR_CTL_IE         0

// Reset values.
`define TWMR_RST_CONTROL    8'h00
`define TWMR_RST_STATUS     8'hF8
`define TWMR_RST_DATA       8'hFF

// Status codes, prescaler bits at zero.
`define TWMR_ST_START       8'h08
`define TWMR_ST_RESTART     8'h10
`define TWMR_ST_AW_ACK      8'h18
`define TWMR_ST_AW_NACK     8'h20
`define TWMR_ST_DW_ACK      8'h28
`define TWMR_ST_DW_NACK     8'h30
`define TWMR_ST_ARB_LOST    8'h38
`define TWMR_ST_AR_ACK      8'h40
`define TWMR_ST_AR_NACK     8'h48
`define TWMR_ST_DR_ACK      8'h50
`define TWMR_ST_DR_NACK     8'h58
`define TWMR_ST_CODE_MASK   8'hF8

// Timing: one quarter of a bus clock period, and the system clock rate.
`define TWMR_QUARTER_NS     200
`define TWMR_CLK_MHZ        10

// Register bus responses.
`define TWMR_RESP_OKAY      2'h0
`define TWMR_RESP_SLVERR    2'h2

`endif

// file: rtl/twmr_pkg.sv
// Types shared by the receive sequencer modules.
package twmr_pkg;

  // Bus sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FREE,
    ST_START,
    ST_STOP,
    ST_BYTE,
    ST_WAIT,
    ST_GO
  } twmr_state_e;

  typedef logic [7:0] twmr_byte_t;

endpackage

// file: rtl/twmr_sync.sv
// Two-flop synchroniser for one line of the serial bus.
`timescale 1ns/10ps
module twmr_sync (
  input  wire logic clk_i,      // System clock.
  input  wire logic reset_n_i,  // Synchronous reset, active low.
  input  wire logic async_i,    // Level from outside the clock domain.
  output logic      sync_o      // Level safe to read in the clock domain.
);

  logic meta_q;

  // The first flop feeds only the second; lines idle high, so reset to one.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// file: rtl/twmr_top.sv
// Master-receive sequencer of the two-wire unit with its register slave.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "twmr_consts.svh"

// Function
// - Device waits for a free bus, then drives the START condition.
// - After START the flag is set and status reads 0x08.
// - After address and acknowledge bit the flag sets with 0x38, 0x40 or 0x48.
// - Status codes assume prescaler bits zero; software masks them.
// - Repeated START reports 0x10; read or write address may follow.
// - 0x38: clear without start releases bus; with start, START when free.
// - 0x40: clear flag; ack_enable selects ACK or NACK for next byte.
// - 0x48: start gives repeated START, stop gives STOP, both give STOP then START.
// - 0x50: byte received and acknowledged; read it, clear flag, choose next ACK.
// - 0x58: byte received with NACK; then repeated START, STOP, or both.
// - Device clears stop_request itself once STOP is driven, also before new START.
// - Data writes while the flag is clear are dropped and set write_collision.
// - While the flag is set all bus activity halts until software clears it.
module twmr_top (
  input  wire logic        clk_i,           // System clock, 10 MHz.
  input  wire logic        reset_n_i,       // Synchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,    // Write address.
  input  wire logic        s_axi_awvalid,   // Write address valid.
  output logic             s_axi_awready,   // Write address ready.
  input  wire logic [31:0] s_axi_wdata,     // Write data.
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
  input  wire logic        s_axi_wvalid,    // Write data valid.
  output logic             s_axi_wready,    // Write data ready.
  output logic [1:0]       s_axi_bresp,     // Write response.
  output logic             s_axi_bvalid,    // Write response valid.
  input  wire logic        s_axi_bready,    // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,    // Read address.
  input  wire logic        s_axi_arvalid,   // Read address valid.
  output logic             s_axi_arready,   // Read address ready.
  output logic [31:0]      s_axi_rdata,     // Read data.
  output logic [1:0]       s_axi_rresp,     // Read response.
  output logic             s_axi_rvalid,    // Read data valid.
  input  wire logic        s_axi_rready,    // Read data ready.
  input  wire logic        scl_i,           // Clock line level.
  output logic             scl_o,           // Clock line drive value, always low.
  output logic             scl_oe_n_o,      // Clock line pulled low when zero.
  input  wire logic        sda_i,           // Data line level.
  output logic             sda_o,           // Data line drive value, always low.
  output logic             sda_oe_n_o,      // Data line pulled low when zero.
  output logic             irq_o            // Interrupt request, active high.
);

  localparam int         QCYC_RAW = (`TWMR_QUARTER_NS * `TWMR_CLK_MHZ) / 1000;
  localparam int         QCYC     = (QCYC_RAW < 1) ? 1 : QCYC_RAW;
  localparam logic [7:0] QLAST    = 8'(QCYC - 1);

  // Status code after a finished byte, chosen from direction and acknowledge.
  function automatic twmr_pkg::twmr_byte_t byte_code(input logic rx, input logic addr,
                                                    input logic rd, input logic ack);
    if (rx) begin
      byte_code = ack ? `TWMR_ST_DR_ACK : `TWMR_ST_DR_NACK;
    end else if (addr && rd) begin
      byte_code = ack ? `TWMR_ST_AR_ACK : `TWMR_ST_AR_NACK;
    end else if (addr) begin
      byte_code = ack ? `TWMR_ST_AW_ACK : `TWMR_ST_AW_NACK;
    end else begin
      byte_code = ack ? `TWMR_ST_DW_ACK : `TWMR_ST_DW_NACK;
    end
  endfunction

  twmr_pkg::twmr_state_e state_q, state_d;
  logic [1:0]            phase_q, phase_d;
  logic [7:0]            qcnt_q, qcnt_d;
  logic [3:0]            bit_q, bit_d;
  twmr_pkg::twmr_byte_t  shift_q, shift_d;
  twmr_pkg::twmr_byte_t  code_q, code_d;
  twmr_pkg::twmr_byte_t  data_q;
  logic                  own_q, own_d;
  logic                  rx_q, rx_d;
  logic                  addr_q, addr_d;
  logic                  rd_q, rd_d;
  logic                  ackout_q, ackout_d;
  logic                  scl_dr_d, sda_dr_d;
  logic                  set_flag, hw_stop_clr, load_rx;
  logic                  flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, ie_q;
  logic [1:0]            presc_q;
  logic                  aw_taken_q, w_taken_q;
  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  scl_s, sda_s, busy;

  twmr_sync u_scl_sync (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(scl_i), .sync_o(scl_s));
  twmr_sync u_sda_sync (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(sda_i), .sync_o(sda_s));
  twmr_bus_monitor u_mon (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .scl_i     (scl_s),
    .sda_i     (sda_s),
    .busy_o    (busy)
  );

  // Register bus decode; a write lands once address and data are both held.
  wire do_wr     = aw_taken_q & w_taken_q & ~s_axi_bvalid;
  wire wr_lane   = wstrb_q[0];
  wire wr_ctl    = do_wr & wr_lane & (awaddr_q == `TWMR_OFS_CONTROL);
  wire wr_stat   = do_wr & wr_lane & (awaddr_q == `TWMR_OFS_STATUS);
  wire wr_data   = do_wr & wr_lane & (awaddr_q == `TWMR_OFS_DATA);
  wire wr_map    = (awaddr_q == `TWMR_OFS_CONTROL) | (awaddr_q == `TWMR_OFS_STATUS) |
                   (awaddr_q == `TWMR_OFS_DATA);
  wire flag_clr  = wr_ctl & wdata_q[`TWMR_CTL_FLAG];
  wire rd_go     = s_axi_arvalid & s_axi_arready;
  wire rd_map    = (s_axi_araddr == `TWMR_OFS_CONTROL) | (s_axi_araddr == `TWMR_OFS_STATUS) |
                   (s_axi_araddr == `TWMR_OFS_DATA);
  wire [7:0] ctl_rd  = {flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, 1'b0, ie_q};
  wire [7:0] stat_rd = {code_q[7:3], 1'b0, presc_q};
  wire [7:0] rd_byte = (s_axi_araddr == `TWMR_OFS_CONTROL) ? ctl_rd :
                       (s_axi_araddr == `TWMR_OFS_STATUS)  ? stat_rd :
                       (s_axi_araddr == `TWMR_OFS_DATA)    ? data_q : 8'h00;

  // Quarter-bit timing; a released clock line that a slave still holds low stretches phase 2.
  wire active  = (state_q == twmr_pkg::ST_START) | (state_q == twmr_pkg::ST_STOP) |
                 (state_q == twmr_pkg::ST_BYTE);
  wire tick    = (qcnt_q == QLAST);
  wire stall   = (phase_q == 2'h2) & ~scl_s;
  wire adv     = active & tick & ~stall;
  wire last    = (bit_q == 4'h8);
  wire tx_bit  = rx_q ? (last ? ~ackout_q : 1'b1) : (last ? 1'b1 : shift_q[7]);
  wire tx_code = (code_q == `TWMR_ST_START) | (code_q == `TWMR_ST_RESTART) |
                 (code_q == `TWMR_ST_AW_ACK) | (code_q == `TWMR_ST_AW_NACK) |
                 (code_q == `TWMR_ST_DW_ACK) | (code_q == `TWMR_ST_DW_NACK);
  wire rx_code = (code_q == `TWMR_ST_AR_ACK) | (code_q == `TWMR_ST_DR_ACK);
  wire addr_code = (code_q == `TWMR_ST_START) | (code_q == `TWMR_ST_RESTART);

  // Bus sequencer. The pin drive bits are the output flops themselves (zero pulls low).
  always_comb begin
    state_d     = state_q;
    phase_d     = phase_q;
    qcnt_d      = (active && !tick) ? qcnt_q + 8'h01 : 8'h00;
    bit_d       = bit_q;
    shift_d     = shift_q;
    code_d      = code_q;
    own_d       = own_q;
    rx_d        = rx_q;
    addr_d      = addr_q;
    rd_d        = rd_q;
    ackout_d    = ackout_q;
    scl_dr_d    = scl_oe_n_o;
    sda_dr_d    = sda_oe_n_o;
    set_flag    = 1'b0;
    hw_stop_clr = 1'b0;
    load_rx     = 1'b0;
    if (adv) begin
      phase_d = phase_q + 2'h1;
    end
    case (state_q)
      twmr_pkg::ST_IDLE: begin
        if (!flag_q && stop_q) begin
          state_d     = own_q ? twmr_pkg::ST_STOP : twmr_pkg::ST_IDLE;
          hw_stop_clr = ~own_q;
          phase_d     = 2'h0;
        end else if (!flag_q && start_q) begin
          state_d = own_q ? twmr_pkg::ST_START : twmr_pkg::ST_FREE;
          phase_d = 2'h0;
        end
      end
      twmr_pkg::ST_FREE: begin
        if (!busy && scl_s && sda_s) begin
          state_d = twmr_pkg::ST_START;
          phase_d = 2'h0;
        end
      end
      twmr_pkg::ST_START: begin
        if (adv) begin
          case (phase_q)
            2'h0: sda_dr_d = 1'b1;
            2'h1: scl_dr_d = 1'b1;
            2'h2: sda_dr_d = 1'b0;
            default: begin
              scl_dr_d = 1'b0;
              code_d   = own_q ? `TWMR_ST_RESTART : `TWMR_ST_START;
              own_d    = 1'b1;
              set_flag = 1'b1;
              state_d  = twmr_pkg::ST_WAIT;
            end
          endcase
        end
      end
      twmr_pkg::ST_STOP: begin
        if (adv) begin
          case (phase_q)
            2'h0: sda_dr_d = 1'b0;
            2'h1: scl_dr_d = 1'b1;
            2'h2: sda_dr_d = 1'b1;
            default: begin
              own_d       = 1'b0;
              hw_stop_clr = 1'b1;
              state_d     = start_q ? twmr_pkg::ST_FREE : twmr_pkg::ST_IDLE;
            end
          endcase
        end
      end
      twmr_pkg::ST_BYTE: begin
        if (adv) begin
          case (phase_q)
            2'h0: sda_dr_d = tx_bit;
            2'h1: scl_dr_d = 1'b1;
            2'h2: begin
              if (!last) begin
                shift_d = {shift_q[6:0], sda_s};
              end
              if ((rx_q == last) && tx_bit && !sda_s) begin
                code_d   = `TWMR_ST_ARB_LOST;
                own_d    = 1'b0;
                sda_dr_d = 1'b1;
                scl_dr_d = 1'b1;
                set_flag = 1'b1;
                state_d  = twmr_pkg::ST_WAIT;
              end
            end
            default: begin
              scl_dr_d = 1'b0;
              bit_d    = bit_q + 4'h1;
              if (last) begin
                code_d   = byte_code(rx_q, addr_q, rd_q, rx_q ? ackout_q : ~sda_s);
                load_rx  = rx_q;
                set_flag = 1'b1;
                state_d  = twmr_pkg::ST_WAIT;
              end
            end
          endcase
        end
      end
      twmr_pkg::ST_WAIT: begin
        if (!flag_q) begin
          state_d = twmr_pkg::ST_GO;
        end
      end
      twmr_pkg::ST_GO: begin
        phase_d = 2'h0;
        bit_d   = 4'h0;
        if (stop_q && own_q) begin
          state_d = twmr_pkg::ST_STOP;
        end else if (start_q) begin
          state_d = own_q ? twmr_pkg::ST_START : twmr_pkg::ST_FREE;
        end else if (!own_q) begin
          state_d  = twmr_pkg::ST_IDLE;
          sda_dr_d = 1'b1;
          scl_dr_d = 1'b1;
        end else if (tx_code) begin
          state_d = twmr_pkg::ST_BYTE;
          rx_d    = 1'b0;
          addr_d  = addr_code;
          rd_d    = addr_code ? data_q[0] : rd_q;
          shift_d = data_q;
        end else if (rx_code) begin
          state_d  = twmr_pkg::ST_BYTE;
          rx_d     = 1'b1;
          addr_d   = 1'b0;
          ackout_d = ack_en_q;
        end else begin
          state_d = twmr_pkg::ST_IDLE;
        end
      end
      default: state_d = twmr_pkg::ST_IDLE;
    endcase
    if (!en_q) begin
      state_d  = twmr_pkg::ST_IDLE;
      own_d    = 1'b0;
      scl_dr_d = 1'b1;
      sda_dr_d = 1'b1;
    end
  end

  // Sequencer state.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q    <= twmr_pkg::ST_IDLE;
      phase_q    <= 2'h0;
      qcnt_q     <= 8'h00;
      bit_q      <= 4'h0;
      shift_q    <= 8'h00;
      own_q      <= 1'b0;
      rx_q       <= 1'b0;
      addr_q     <= 1'b0;
      rd_q       <= 1'b0;
      ackout_q   <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      qcnt_q     <= qcnt_d;
      bit_q      <= bit_d;
      shift_q    <= shift_d;
      own_q      <= own_d;
      rx_q       <= rx_d;
      addr_q     <= addr_d;
      rd_q       <= rd_d;
      ackout_q   <= ackout_d;
      scl_oe_n_o <= scl_dr_d;
      sda_oe_n_o <= sda_dr_d;
    end
  end

  // Control, status and data registers. A hardware set of the flag wins over a clear.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      {flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, ie_q} <= 7'h00;
      code_q  <= `TWMR_RST_STATUS;
      presc_q <= 2'h0;
      data_q  <= `TWMR_RST_DATA;
      irq_o   <= 1'b0;
    end else begin
      flag_q <= set_flag | (flag_q & ~flag_clr);
      code_q <= code_d;
      irq_o  <= flag_q & ie_q;
      if (hw_stop_clr) begin
        stop_q <= 1'b0;
      end
      if (wr_ctl) begin
        ack_en_q <= wdata_q[`TWMR_CTL_ACK_EN];
        start_q  <= wdata_q[`TWMR_CTL_START];
        stop_q   <= wdata_q[`TWMR_CTL_STOP] | (stop_q & ~hw_stop_clr);
        en_q     <= wdata_q[`TWMR_CTL_ENABLE];
        ie_q     <= wdata_q[`TWMR_CTL_IE];
      end
      if (wr_stat) begin
        presc_q <= wdata_q[1:0];
      end
      if (load_rx) begin
        data_q <= shift_q;
      end else if (wr_data && flag_q) begin
        data_q <= wdata_q[7:0];
        wcol_q <= 1'b0;
      end else if (wr_data) begin
        wcol_q <= 1'b1;
      end
    end
  end

  // Register bus handshakes: one write and one read at a time.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_taken_q    <= 1'b0;
      w_taken_q     <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TWMR_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TWMR_RESP_OKAY;
      scl_o         <= 1'b0;
      sda_o         <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_taken_q    <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_taken_q    <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `TWMR_RESP_OKAY : `TWMR_RESP_SLVERR;
        aw_taken_q   <= 1'b0;
        w_taken_q    <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_map ? `TWMR_RESP_OKAY : `TWMR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
